/* File: inc/bcc_consts.vh */
// Purpose: constants of the bcd calendar clock: offsets, fields, resets, limits
// Assumes: included by core/bcc_clock.v and by the bench monitor and testbench
// Notes:   all offsets are byte addresses on the plain register port
`ifndef BCC_CONSTS_VH
`define BCC_CONSTS_VH

// register byte offsets
`define BCC_OFS_CTRL     8'h00
`define BCC_OFS_MODE     8'h04
`define BCC_OFS_TIME     8'h08
`define BCC_OFS_CAL      8'h0c
`define BCC_OFS_TIMALM   8'h10
`define BCC_OFS_CALALM   8'h14
`define BCC_OFS_STAT     8'h18
`define BCC_OFS_STCLR    8'h1c
`define BCC_OFS_IEN      8'h20
`define BCC_OFS_IDIS     8'h24
`define BCC_OFS_IMASK    8'h28
`define BCC_OFS_VALID    8'h2c

// status bit positions (also interrupt enable and mask positions)
`define BCC_ST_ACK       0
`define BCC_ST_ALARM     1
`define BCC_ST_SEC       2
`define BCC_ST_TIMEV     3
`define BCC_ST_CALEV     4
`define BCC_ST_W         5

// validity bit positions
`define BCC_NV_TIME      0
`define BCC_NV_CAL       1
`define BCC_NV_TIMALM    2
`define BCC_NV_CALALM    3

// control fields
`define BCC_CR_UPDTIME   0
`define BCC_CR_CALENDAR_UPDATE_REQUEST    1
`define BCC_CR_TEVLO     8
`define BCC_CR_CEVLO     16

// time and alarm layout
`define BCC_F_SEC        6:0
`define BCC_F_MIN        14:8
`define BCC_F_HOUR       21:16
`define BCC_B_PM         22
`define BCC_B_SECEN      7
`define BCC_B_MINEN      15
`define BCC_B_HOUREN     23
// calendar and calendar alarm layout
`define BCC_F_CENT       6:0
`define BCC_F_YEAR       15:8
`define BCC_F_MONTH      20:16
`define BCC_F_DAY        23:21
`define BCC_F_DATE       29:24
`define BCC_B_MONEN      23
`define BCC_B_DATEEN     31

// reset values: thursday 1 january 1998, 00:00:00
`define BCC_RST_CENT     7'h19
`define BCC_RST_YEAR     8'h98
`define BCC_RST_MONTH    5'h01
`define BCC_RST_DATE     6'h01
`define BCC_RST_DAY      3'h4
`define BCC_RST_CALALM   32'h01010000

// bcd limits
`define BCC_MAX_SEC      8'h59
`define BCC_MAX_H24      8'h23
`define BCC_MAX_H12      8'h12
`define BCC_MAX_MONTH    8'h12
`define BCC_MAX_DAY      3'h7
`define BCC_CENT_LO      7'h19
`define BCC_CENT_HI      7'h20
`define BCC_MAX_YEAR     8'h99
`define BCC_MAX_DIGIT    4'h9

// slow reference rate in hz
`define BCC_SLOW_HZ      32768

`endif

/* File: core/bcc_clock.v */
// Purpose: bcd time-of-day clock, 1900-2099 calendar, field-masked alarm
// Assumes: ref_clk 100 MHz; slow_reference_clock 32768 Hz arrives as a pin
// Notes:   time is held in 24-hour form; 12-hour writes are converted on entry
//
// What this block does
// - keep century, year, month, date, weekday, hours, minutes, seconds in packed bcd
// - calendar spans 1900 to 2099; century steps 19 to 20 at year 2000
// - february has 29 days whenever two-digit year divides by 4
// - reset loads thursday 1 january 1998 with time at zero
// - hours are entered in 24-hour form or 12-hour form with am/pm, per mode bit
// - clock runs continuously from the 32768 hz slow reference, never gated
// - seconds step once a second; each higher counter steps on lower rollover
// - alarm compares five fields each with enable; full match sets flag and interrupt
// - seconds-only alarm fires once each minute at the matching second
// - rejected time, calendar or alarm writes leave target unchanged, set validity flag
// - validity flags clear only on a later acceptable write to that register
// - reject century other than 19 or 20 and year not valid bcd
// - reject date outside 01-31 or month, month outside 01-12, weekday outside 1-7
// - 24-hour: reject hours over 23 or pm set; 12-hour: reject outside 01-12
// - reject minutes or seconds not bcd or above 59
// - 12-hour range uses pm at bit 22; readback shows equivalent 24-hour value
// - update request bits stop their counters while set
// - device sets update acknowledge; software writes only after seeing it
// - during a calendar-only update the time counters keep running
// - time request halts second, minute, hour; calendar request halts day through century
//
// The implementer's own choices: the address map and the plain strobed port.
`timescale 1ns/100ps
`default_nettype none
`include "bcc_consts.vh"

module bcc_clock #(
  parameter SLOW_HZ = `BCC_SLOW_HZ
) (
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        slow_reference_clock,
  input  wire [7:0]  bus_addr,
  input  wire [31:0] bus_wdata,
  input  wire        bus_wr,
  input  wire        bus_rd,
  output reg  [31:0] bus_rdata,
  output wire        irq
);

  ////////////////////////////////////////////////////////////////////////////
  // bcd helpers

  function bcd_ok;
    input [7:0] v;
    begin
      bcd_ok = (v[3:0] <= `BCC_MAX_DIGIT) && (v[7:4] <= `BCC_MAX_DIGIT);
    end
  endfunction

  function [7:0] bcd_inc;
    input [7:0] v;
    begin
      if (v[3:0] == `BCC_MAX_DIGIT)
        bcd_inc = {v[7:4] + 4'h1, 4'h0};
      else
        bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // last date of a month, bcd; leap when (10*t + u) mod 4 == 0
  function [7:0] last_date;
    input [4:0] mon;
    input [7:0] yr;
    reg   [1:0] m4;
    begin
      m4 = {yr[4], 1'b0} + yr[1:0];
      if (mon == 5'h02)
        last_date = (m4 == 2'b00) ? 8'h29 : 8'h28;
      else if (mon == 5'h04 || mon == 5'h06 || mon == 5'h09 || mon == 5'h11)
        last_date = 8'h30;
      else
        last_date = 8'h31;
    end
  endfunction

  // 12-hour entry to 24-hour bcd; 12 am is 00, 12 pm is 12
  function [5:0] to_h24;
    input [5:0] h;
    input       pm;
    input       mode12;
    reg   [4:0] b;
    reg   [4:0] t;
    reg   [4:0] u;
    begin
      b = h[5:4] * 5'd10 + {1'b0, h[3:0]};
      if (b == 5'd12)
        b = 5'd0;
      if (pm)
        b = b + 5'd12;
      t = b / 5'd10;
      u = b - t * 5'd10;
      if (mode12)
        to_h24 = {t[1:0], u[3:0]};
      else
        to_h24 = h;
    end
  endfunction

  // hour entry check by format
  function hour_ok;
    input [5:0] h;
    input       pm;
    input       mode12;
    begin
      if (mode12)
        hour_ok = bcd_ok({2'b00, h}) && h != 6'h00 && {2'b00, h} <= `BCC_MAX_H12;
      else
        hour_ok = bcd_ok({2'b00, h}) && {2'b00, h} <= `BCC_MAX_H24 && !pm;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // slow reference: three stages, a change counts when stages two and three agree

  reg [2:0]  slow_sync_ff;
  reg        slow_lvl_ff;
  reg [15:0] pre_ff;
  reg        tick_ff;
  wire       slow_rise = (slow_sync_ff[1] == slow_sync_ff[2]) && slow_sync_ff[2] && !slow_lvl_ff;
  // prescaler end point, cut to the counter width on purpose
  localparam [31:0] PRE_LAST_W = SLOW_HZ - 1;
  localparam [15:0] PRE_LAST   = PRE_LAST_W[15:0];

  // free running divider; no mode or power bit gates it
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      slow_sync_ff <= 3'h0;
      slow_lvl_ff  <= 1'b0;
      pre_ff       <= 16'h0;
      tick_ff      <= 1'b0;
    end else begin
      slow_sync_ff <= {slow_sync_ff[1:0], slow_reference_clock};
      if (slow_sync_ff[1] == slow_sync_ff[2])
        slow_lvl_ff <= slow_sync_ff[2];
      tick_ff <= 1'b0;
      if (slow_rise) begin
        if (pre_ff == PRE_LAST) begin
          pre_ff  <= 16'h0;
          tick_ff <= 1'b1;
        end else begin
          pre_ff <= pre_ff + 16'h1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers and counters

  reg [1:0]  upd_ff;
  reg [1:0]  tev_sel_ff;
  reg [1:0]  cev_sel_ff;
  reg        mode12_ff;
  reg [6:0]  sec_ff, min_ff, cent_ff;
  reg [5:0]  hour_ff, date_ff;
  reg [4:0]  mon_ff;
  reg [7:0]  year_ff;
  reg [2:0]  day_ff;
  reg [23:0] talm_ff;
  reg [31:0] calm_ff;
  reg [4:0]  stat_ff, imask_ff;
  reg [3:0]  nv_ff;
  reg        match_d_ff;

  wire upd_time = upd_ff[`BCC_CR_UPDTIME];
  wire upd_cal  = upd_ff[`BCC_CR_CALENDAR_UPDATE_REQUEST];
  wire wr_ctrl  = bus_wr && bus_addr == `BCC_OFS_CTRL;
  wire wr_time  = bus_wr && bus_addr == `BCC_OFS_TIME && upd_time;
  wire wr_cal   = bus_wr && bus_addr == `BCC_OFS_CAL && upd_cal;
  wire wr_talm  = bus_wr && bus_addr == `BCC_OFS_TIMALM;
  wire wr_calm  = bus_wr && bus_addr == `BCC_OFS_CALALM;

  // entry checks on the written word
  wire [5:0] w_hour  = bus_wdata[`BCC_F_HOUR];
  wire       w_pm    = bus_wdata[`BCC_B_PM];
  wire [4:0] w_mon   = bus_wdata[`BCC_F_MONTH];
  wire [5:0] w_date  = bus_wdata[`BCC_F_DATE];
  wire [7:0] w_year  = bus_wdata[`BCC_F_YEAR];
  wire ms_ok  = bcd_ok({1'b0, bus_wdata[`BCC_F_SEC]}) &&
                {1'b0, bus_wdata[`BCC_F_SEC]} <= `BCC_MAX_SEC &&
                bcd_ok({1'b0, bus_wdata[`BCC_F_MIN]}) &&
                {1'b0, bus_wdata[`BCC_F_MIN]} <= `BCC_MAX_SEC;
  wire time_ok = ms_ok && hour_ok(w_hour, w_pm, mode12_ff);
  wire mon_ok = bcd_ok({3'b000, w_mon}) && w_mon != 5'h00 &&
                {3'b000, w_mon} <= `BCC_MAX_MONTH;
  wire date_ok = bcd_ok({2'b00, w_date}) && w_date != 6'h00 &&
                 {2'b00, w_date} <= last_date(w_mon, w_year);
  wire cal_ok = (bus_wdata[`BCC_F_CENT] == `BCC_CENT_LO ||
                 bus_wdata[`BCC_F_CENT] == `BCC_CENT_HI) &&
                bcd_ok(w_year) && mon_ok && date_ok &&
                bus_wdata[`BCC_F_DAY] != 3'h0;
  // alarm date is checked against the current year
  wire calm_ok = mon_ok && bcd_ok({2'b00, w_date}) && w_date != 6'h00 &&
                 {2'b00, w_date} <= last_date(w_mon, year_ff);

  // rollover chain, halted per request
  wire run_time  = tick_ff && !upd_time;
  wire sec_wrap  = {1'b0, sec_ff} == `BCC_MAX_SEC;
  wire min_wrap  = {1'b0, min_ff} == `BCC_MAX_SEC;
  wire hour_wrap = {2'b00, hour_ff} == `BCC_MAX_H24;
  wire min_step  = run_time && sec_wrap;
  wire hour_step = min_step && min_wrap;
  wire day_step  = hour_step && hour_wrap;
  wire cal_step  = day_step && !upd_cal;
  wire date_wrap = {2'b00, date_ff} == last_date(mon_ff, year_ff);
  wire mon_wrap  = {3'b000, mon_ff} == `BCC_MAX_MONTH;
  wire year_wrap = year_ff == `BCC_MAX_YEAR;
  wire [7:0] sec_n  = bcd_inc({1'b0, sec_ff});
  wire [7:0] min_n  = bcd_inc({1'b0, min_ff});
  wire [7:0] hour_n = bcd_inc({2'b00, hour_ff});
  wire [7:0] date_n = bcd_inc({2'b00, date_ff});
  wire [7:0] mon_n  = bcd_inc({3'b000, mon_ff});
  wire [7:0] year_n = bcd_inc(year_ff);

  // time counters: bus load only under a time request
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sec_ff  <= 7'h00;
      min_ff  <= 7'h00;
      hour_ff <= 6'h00;
    end else if (wr_time) begin
      if (time_ok) begin
        sec_ff  <= bus_wdata[`BCC_F_SEC];
        min_ff  <= bus_wdata[`BCC_F_MIN];
        hour_ff <= to_h24(w_hour, w_pm, mode12_ff);
      end
    end else if (run_time) begin
      sec_ff <= sec_wrap ? 7'h00 : sec_n[6:0];
      if (min_step)
        min_ff <= min_wrap ? 7'h00 : min_n[6:0];
      if (hour_step)
        hour_ff <= hour_wrap ? 6'h00 : hour_n[5:0];
    end
  end

  // calendar counters
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cent_ff <= `BCC_RST_CENT;
      year_ff <= `BCC_RST_YEAR;
      mon_ff  <= `BCC_RST_MONTH;
      date_ff <= `BCC_RST_DATE;
      day_ff  <= `BCC_RST_DAY;
    end else if (wr_cal) begin
      if (cal_ok) begin
        cent_ff <= bus_wdata[`BCC_F_CENT];
        year_ff <= w_year;
        mon_ff  <= w_mon;
        date_ff <= w_date;
        day_ff  <= bus_wdata[`BCC_F_DAY];
      end
    end else if (cal_step) begin
      day_ff <= (day_ff == `BCC_MAX_DAY) ? 3'h1 : day_ff + 3'h1;
      date_ff <= date_wrap ? `BCC_RST_DATE : date_n[5:0];
      if (date_wrap) begin
        mon_ff <= mon_wrap ? `BCC_RST_MONTH : mon_n[4:0];
        if (mon_wrap) begin
          year_ff <= year_wrap ? 8'h00 : year_n;
          if (year_wrap)
            cent_ff <= `BCC_CENT_HI;
        end
      end
    end
  end

  // alarm compare, raised on the first cycle of a full match
  wire any_en = talm_ff[`BCC_B_SECEN] | talm_ff[`BCC_B_MINEN] | talm_ff[`BCC_B_HOUREN] |
                calm_ff[`BCC_B_MONEN] | calm_ff[`BCC_B_DATEEN];
  wire match = any_en &&
    (!talm_ff[`BCC_B_SECEN]  || talm_ff[`BCC_F_SEC]  == sec_ff) &&
    (!talm_ff[`BCC_B_MINEN]  || talm_ff[`BCC_F_MIN]  == min_ff) &&
    (!talm_ff[`BCC_B_HOUREN] || talm_ff[`BCC_F_HOUR] == hour_ff) &&
    (!calm_ff[`BCC_B_MONEN]  || calm_ff[`BCC_F_MONTH] == mon_ff) &&
    (!calm_ff[`BCC_B_DATEEN] || calm_ff[`BCC_F_DATE] == date_ff);
  wire alarm_ev = match && !match_d_ff;

  // periodic events picked by the control selects
  reg tev, cev;
  always @* begin
    case (tev_sel_ff)
      2'h0:    tev = min_step;
      2'h1:    tev = hour_step;
      2'h2:    tev = day_step;
      default: tev = hour_step && hour_ff == 6'h11;
    endcase
    case (cev_sel_ff)
      2'h0:    cev = cal_step && day_ff == `BCC_MAX_DAY;
      2'h1:    cev = cal_step && date_wrap;
      default: cev = cal_step && date_wrap && mon_wrap;
    endcase
  end

  // request rising edge acknowledges at once; set wins over clear
  wire req_rise = wr_ctrl && upd_ff == 2'b00 &&
                  (bus_wdata[`BCC_CR_UPDTIME] | bus_wdata[`BCC_CR_CALENDAR_UPDATE_REQUEST]);
  wire [4:0] st_set = {cev, tev, tick_ff, alarm_ev, req_rise};
  wire [4:0] st_clr = (bus_wr && bus_addr == `BCC_OFS_STCLR) ?
                      bus_wdata[`BCC_ST_W-1:0] : 5'h00;

  // control, mode, alarm, status, mask and validity state
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      upd_ff     <= 2'b00;
      tev_sel_ff <= 2'h0;
      cev_sel_ff <= 2'h0;
      mode12_ff  <= 1'b0;
      talm_ff    <= 24'h0;
      calm_ff    <= `BCC_RST_CALALM;
      stat_ff    <= 5'h00;
      imask_ff   <= 5'h00;
      nv_ff      <= 4'h0;
      match_d_ff <= 1'b0;
    end else begin
      match_d_ff <= match;
      if (wr_ctrl) begin
        upd_ff     <= bus_wdata[1:0];
        tev_sel_ff <= bus_wdata[`BCC_CR_TEVLO+1:`BCC_CR_TEVLO];
        cev_sel_ff <= bus_wdata[`BCC_CR_CEVLO+1:`BCC_CR_CEVLO];
      end
      if (bus_wr && bus_addr == `BCC_OFS_MODE)
        mode12_ff <= bus_wdata[0];
      stat_ff <= (stat_ff & ~st_clr) | st_set;
      if (bus_wr && bus_addr == `BCC_OFS_IEN)
        imask_ff <= imask_ff | bus_wdata[`BCC_ST_W-1:0];
      if (bus_wr && bus_addr == `BCC_OFS_IDIS)
        imask_ff <= imask_ff & ~bus_wdata[`BCC_ST_W-1:0];
      // flags follow the last write only; software has no clear
      if (wr_time)
        nv_ff[`BCC_NV_TIME] <= !time_ok;
      if (wr_cal)
        nv_ff[`BCC_NV_CAL] <= !cal_ok;
      if (wr_talm) begin
        nv_ff[`BCC_NV_TIMALM] <= !time_ok;
        if (time_ok)
          talm_ff <= {bus_wdata[`BCC_B_HOUREN], 1'b0,
                      to_h24(w_hour, w_pm, mode12_ff), bus_wdata[15:0]};
      end
      if (wr_calm) begin
        nv_ff[`BCC_NV_CALALM] <= !calm_ok;
        if (calm_ok)
          calm_ff <= {bus_wdata[31:30], w_date, bus_wdata[23:21], w_mon, 16'h0000};
      end
    end
  end

  assign irq = |(stat_ff & imask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the strobe, unmapped reads zero

  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bus_rdata <= 32'h0;
    end else if (bus_rd) begin
      case (bus_addr)
        `BCC_OFS_CTRL:   bus_rdata <= {14'h0, cev_sel_ff, 6'h0, tev_sel_ff, 6'h0, upd_ff};
        `BCC_OFS_MODE:   bus_rdata <= {31'h0, mode12_ff};
        `BCC_OFS_TIME:   bus_rdata <= {10'h0, hour_ff, 1'b0, min_ff, 1'b0, sec_ff};
        `BCC_OFS_CAL:    bus_rdata <= {2'h0, date_ff, day_ff, mon_ff, year_ff, 1'b0, cent_ff};
        `BCC_OFS_TIMALM: bus_rdata <= {8'h0, talm_ff};
        `BCC_OFS_CALALM: bus_rdata <= calm_ff;
        `BCC_OFS_STAT:   bus_rdata <= {27'h0, stat_ff};
        `BCC_OFS_IMASK:  bus_rdata <= {27'h0, imask_ff};
        `BCC_OFS_VALID:  bus_rdata <= {28'h0, nv_ff};
        default:         bus_rdata <= 32'h0;
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: core/bcc_clock_fix_note.v */
`timescale 1ns/100ps
`default_nettype none
`default_nettype wire

/* File: bench/bcc_monitor.sv */
// Purpose: port checker for the bcd calendar clock
// Assumes: sees only the top ports; one clock domain
// Notes:   read-back fields must stay in range whatever was written
`timescale 1ns/100ps
`default_nettype none
`include "bcc_consts.vh"
module bcc_monitor (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic [7:0]  bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic        irq
);
  logic [4:0] msk_ff;
  logic [7:0] ra_ff;
  logic       rv_ff;
  logic       tr;
  logic       cr;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // shadow of the mask and of the read in flight, so data can be tied to its address
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      msk_ff <= 5'h00;
      ra_ff  <= 8'h00;
      rv_ff  <= 1'b0;
    end else begin
      rv_ff <= bus_rd;
      ra_ff <= bus_addr;
      if (bus_wr && bus_addr == `BCC_OFS_IEN) begin
        msk_ff <= msk_ff | bus_wdata[4:0];
      end else if (bus_wr && bus_addr == `BCC_OFS_IDIS) begin
        msk_ff <= msk_ff & ~bus_wdata[4:0];
      end
    end
  end
  // read data of time and calendar stands in the cycle after the strobe
  assign tr = rv_ff && ra_ff == `BCC_OFS_TIME;
  assign cr = rv_ff && ra_ff == `BCC_OFS_CAL;
  property p_sec;
    tr |-> bus_rdata[3:0] <= 4'h9 && bus_rdata[6:0] <= 7'h59;
  endproperty
  a_sec: assert property (p_sec) else $error("seconds out of range");
  property p_min;
    tr |-> bus_rdata[11:8] <= 4'h9 && bus_rdata[14:8] <= 7'h59;
  endproperty
  a_min: assert property (p_min) else $error("minutes out of range");
  property p_hour;
    tr |-> bus_rdata[21:16] <= 6'h23 && !bus_rdata[22];
  endproperty
  a_hour: assert property (p_hour) else $error("hour not in 24-hour form");
  property p_cent;
    cr |-> bus_rdata[6:0] == 7'h19 || bus_rdata[6:0] == 7'h20;
  endproperty
  a_cent: assert property (p_cent) else $error("century out of range");
  property p_year;
    cr |-> bus_rdata[11:8] <= 4'h9 && bus_rdata[15:12] <= 4'h9;
  endproperty
  a_year: assert property (p_year) else $error("year not bcd");
  property p_mon;
    cr |-> bus_rdata[20:16] >= 5'h01 && bus_rdata[20:16] <= 5'h12 && bus_rdata[19:16] <= 4'h9;
  endproperty
  a_mon: assert property (p_mon) else $error("month out of range");
  property p_date;
    cr |-> bus_rdata[29:24] >= 6'h01 && bus_rdata[29:24] <= 6'h31 && bus_rdata[27:24] <= 4'h9;
  endproperty
  a_date: assert property (p_date) else $error("date out of range");
  property p_day;
    $past(bus_rd) && $past(bus_addr) == `BCC_OFS_CAL |-> bus_rdata[23:21] != 3'h0;
  endproperty
  a_day: assert property (p_day) else $error("weekday zero");
  property p_irq;
    irq |-> msk_ff != 5'h00;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt while masked");
endmodule
bind bcc_clock bcc_monitor u_mon (.ref_clk(ref_clk), .rst(rst), .bus_addr(bus_addr),
  .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq));
`default_nettype wire

/* File: bench/bcc_slow_src.sv */
// Purpose: slow reference oscillator seen by the clock block
// Assumes: period shortened for simulation
// Notes:   free running, phase unrelated to ref_clk
`timescale 1ns/100ps
`default_nettype none
module bcc_slow_src #(
  parameter int HALF_NS = 100
) (
  output var logic slow_reference_clock
);
  // never gated: the oscillator keeps going in every power state
  initial begin
    slow_reference_clock = 1'b0;
    #3;
    forever #(HALF_NS) slow_reference_clock = ~slow_reference_clock;
  end
endmodule
`default_nettype wire

/* File: bench/tb.sv */
// Purpose: self-checking bench for the bcd calendar clock
// Assumes: one second is 4 slow cycles of 200 ns, so 80 ref_clk cycles
// Notes:   table rows cover entry checks; hand tests cover counting and alarm
`timescale 1ns/100ps
`default_nettype none
`include "bcc_consts.vh"
module tb;
  typedef struct packed {
    logic        m12;
    logic [7:0]  a;
    logic [31:0] d;
    logic [31:0] e;
    logic [3:0]  v;
  } bcc_row_t;
  localparam logic [7:0] a_ctl = `BCC_OFS_CTRL;
  localparam logic [7:0] a_tim = `BCC_OFS_TIME;
  localparam logic [7:0] a_cal = `BCC_OFS_CAL;
  localparam logic [7:0] a_tal = `BCC_OFS_TIMALM;
  localparam logic [7:0] a_cla = `BCC_OFS_CALALM;
  localparam logic [7:0] a_st  = `BCC_OFS_STAT;
  localparam logic [7:0] a_scl = `BCC_OFS_STCLR;
  logic        ref_clk = 1'b0;
  logic        rst;
  logic        slow_reference_clock;
  logic [7:0]  bus_addr;
  logic [31:0] bus_wdata;
  logic        bus_wr;
  logic        bus_rd;
  logic [31:0] bus_rdata;
  logic        irq;
  logic [31:0] d;
  logic [31:0] t0;
  logic        hit;
  int          n;
  int          num_errors = 0;
  int          checks_done = 0;
  // entry checks: mode, target, written, read back, validity after
  bcc_row_t rows [19] = '{
    '{1'b0, a_tim, 32'h00235959, 32'h00235959, 4'h0}, '{1'b0, a_tim, 32'h00245959, 32'h00235959, 4'h1},
    '{1'b0, a_tim, 32'h00400000, 32'h00235959, 4'h1}, '{1'b0, a_tim, 32'h00006000, 32'h00235959, 4'h1},
    '{1'b0, a_tim, 32'h0000000a, 32'h00235959, 4'h1}, '{1'b1, a_tim, 32'h00511030, 32'h00231030, 4'h0},
    '{1'b1, a_tim, 32'h00130000, 32'h00231030, 4'h1}, '{1'b1, a_tim, 32'h00120000, 32'h00000000, 4'h0},
    '{1'b0, a_cal, 32'h01819821, 32'h01819819, 4'h2}, '{1'b0, a_cal, 32'h01819a19, 32'h01819819, 4'h2},
    '{1'b0, a_cal, 32'h29420020, 32'h29420020, 4'h0}, '{1'b0, a_cal, 32'h29429919, 32'h29420020, 4'h2},
    '{1'b0, a_cal, 32'h01330020, 32'h29420020, 4'h2}, '{1'b0, a_cal, 32'h01010020, 32'h29420020, 4'h2},
    '{1'b0, a_cal, 32'h32210020, 32'h29420020, 4'h2}, '{1'b0, a_tal, 32'h00000060, 32'h00000000, 4'h6},
    '{1'b0, a_tal, 32'h00000085, 32'h00000085, 4'h2}, '{1'b0, a_cla, 32'h00930000, 32'h01010000, 4'ha},
    '{1'b0, a_cla, 32'h01010000, 32'h01010000, 4'h2}};
  // calendar before and after a midnight rollover
  logic [63:0] rl [3] = '{64'h31b29919_01c10020, 64'h28220020_29420020, 64'h28220120_01430120};
  bcc_slow_src #(.HALF_NS(100)) u_src (.slow_reference_clock(slow_reference_clock));
  bcc_clock #(.SLOW_HZ(4)) uut (.ref_clk(ref_clk), .rst(rst),
    .slow_reference_clock(slow_reference_clock), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
    .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata), .irq(irq));
  always #5 ref_clk = ~ref_clk;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    bus_addr  <= a;
    bus_wdata <= v;
    bus_wr    <= 1'b1;
    @(posedge ref_clk);
    bus_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge ref_clk);
    bus_addr <= a;
    bus_rd   <= 1'b1;
    @(posedge ref_clk);
    bus_rd   <= 1'b0;
    #1;
    v = bus_rdata;
  endtask
  // poll one status bit, bounded
  task automatic wt(input int b, input int lim);
    logic [31:0] v;
    hit = 1'b0;
    for (int k = 0; k < lim && hit !== 1'b1; k++) begin
      rd(a_st, v);
      hit = v[b];
    end
  endtask
  task automatic upd_begin(input logic [31:0] c);
    wr(a_ctl, c);
    wt(`BCC_ST_ACK, 20);
    chk({31'h0, hit}, 32'h1);
  endtask
  // release, then keep one tick apart before the next request
  task automatic upd_end();
    wr(a_ctl, 32'h0);
    wr(a_scl, 32'h1f);
    wt(`BCC_ST_SEC, 300);
    chk({31'h0, hit}, 32'h1);
    wr(a_scl, 32'h1f);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // watchdog: the whole run needs well under 20000 cycles
  initial begin
    #400000;
    num_errors++;
    end_sim();
  end
  initial begin
    rst = 1'b1;
    bus_addr = 8'h00;
    bus_wdata = 32'h0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    // counters stay frozen across all rows, so a refused write leaves a known value
    upd_begin(32'h3);
    for (int i = 0; i < 19; i++) begin
      wr(`BCC_OFS_MODE, {31'h0, rows[i].m12});
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, d);
      chk(d, rows[i].e);
      rd(`BCC_OFS_VALID, d);
      chk(d, {28'h0, rows[i].v});
      $display("row %0d done", i);
    end
    upd_end();
    // one second past 23:59:59 at century end, leap-year february 28 and month end
    for (int i = 0; i < 3; i++) begin
      // minute event always, year event only across the new year
      upd_begin(32'h00020003);
      wr(a_tim, 32'h00235959);
      wr(a_cal, rl[i][63:32]);
      wr(a_ctl, 32'h00020000);
      d = 32'h00235959;
      for (int k = 0; k < 300 && d === 32'h00235959; k++) begin
        rd(a_tim, d);
      end
      chk(d, 32'h0);
      rd(a_st, d);
      chk({30'h0, d[4:3]}, {30'h0, i == 0, 1'b1});
      rd(a_cal, d);
      chk(d, rl[i][31:0]);
      upd_end();
    end
    $display("rollover test done");
    // time request freezes time; calendar-only request lets it run
    for (int i = 1; i < 3; i++) begin
      upd_begin(32'(i));
      rd(a_tim, t0);
      repeat (200) @(posedge ref_clk);
      rd(a_tim, d);
      chk({31'h0, d === t0}, {31'h0, i == 1});
      upd_end();
    end
    $display("halt test done");
    // seconds-only alarm at :05, then again one minute later
    wr(`BCC_OFS_IEN, 32'h2);
    wr(a_scl, 32'h1f);
    for (n = 0; n < 6000 && irq !== 1'b1; n++) @(posedge ref_clk);
    rd(a_tim, d);
    chk({25'h0, d[6:0]}, 32'h05);
    wr(a_scl, 32'h2);
    #1;
    chk({31'h0, irq}, 32'h0);
    for (n = 0; n < 6000 && irq !== 1'b1; n++) @(posedge ref_clk);
    chk({31'h0, n > 4700 && n < 4900}, 32'h1);
    wr(`BCC_OFS_IDIS, 32'h2);
    #1;
    chk({31'h0, irq}, 32'h0);
    $display("alarm test done");
    // second reset in mid-run, then reset values and an unmapped place
    rst <= 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    rd(a_tim, d);
    chk(d, 32'h0);
    rd(a_cal, d);
    chk(d, 32'h01819819);
    rd(a_cla, d);
    chk(d, 32'h01010000);
    rd(8'h40, d);
    chk(d, 32'h0);
    $display("reset test done");
    end_sim();
  end
endmodule
`default_nettype wire
